// File: rtl/brake_seq.sv
// Holding-brake output sequencer: drive enable and brake relay pin.
// Assumes synchronous command pulses and one 50 MHz clock.
`timescale 1ns/100ps
`include "brake_seq_defs.svh"
module brake_seq
  import brake_seq_pkg::*;
#(
  parameter int SPEED_W     = 16,
  parameter int MODE_W      = 3,
  parameter int MS_TICK_CYC = `BSQ_NS_PER_MS / `BSQ_CLK_PERIOD_NS,
  parameter int STOP_QUAL_CYC = `BSQ_STOP_QUAL_MS * (`BSQ_NS_PER_MS / `BSQ_CLK_PERIOD_NS),
  parameter int ENABLE_MAX_CYC = `BSQ_ENABLE_MAX_NS / `BSQ_CLK_PERIOD_NS
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               enable_cmd_i,
  input  wire logic               disable_cmd_i,
  input  wire logic               torque_cut_input_i,
  input  wire logic               feedback_lost_i,
  input  wire logic [SPEED_W-1:0] speed_i,
  input  wire logic [SPEED_W-1:0] halt_velocity_threshold_i,
  input  wire logic [15:0]        brake_hold_time_i,
  input  wire logic [MODE_W-1:0]  out_mode_i,
  input  wire logic               polarity_invert_i,
  input  wire logic               user_out_i,
  output logic                    drive_enabled_o,
  output logic                    brake_release_o,
  output logic                    out_pin_o,
  output logic                    ramp_active_o,
  output logic [1:0]              state_o
);

  seq_regs_t r;
  seq_regs_t next_r;
  logic      fault;
  logic      stopped;
  logic      tick_done;
  logic      brake_mode;
  logic      pin_level;

  assign fault      = torque_cut_input_i | feedback_lost_i;
  assign tick_done  = r.tick >= 16'(MS_TICK_CYC - 1);
  assign brake_mode = out_mode_i == `BSQ_OUT_MODE_BRAKE;

  // Speed must stay low for the full interval before holding starts
  stop_qualifier #(
    .QUAL_CYC (STOP_QUAL_CYC),
    .SPEED_W  (SPEED_W)
  ) u_qual (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .arm_i       (r.mode == ST_RAMP),
    .speed_i     (speed_i),
    .threshold_i (halt_velocity_threshold_i),
    .stopped_o   (stopped)
  );

  // Sequencing: fault beats disable beats enable
  always_comb begin
    next_r = r;
    next_r.tick = 16'h0000;
    case (r.mode)
      ST_DISABLED: begin
        if (enable_cmd_i && !disable_cmd_i && !fault) begin
          next_r.mode = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (disable_cmd_i) begin
          next_r.mode = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (disable_cmd_i) begin
          next_r.mode = ST_DISABLED;
        end else if (stopped) begin
          next_r.mode      = ST_HOLD;
          next_r.hold_left = brake_hold_time_i;
        end
      end
      ST_HOLD: begin
        if (disable_cmd_i) begin
          next_r.mode = ST_DISABLED;
        end else if (r.hold_left == 16'h0000) begin
          next_r.mode = ST_DISABLED;
        end else if (tick_done) begin
          next_r.hold_left = r.hold_left - 16'h0001;
        end else begin
          next_r.tick = r.tick + 16'h0001;
        end
      end
      default: begin
        next_r.mode = ST_DISABLED;
      end
    endcase
    // Fault skips the hold wait entirely
    if (fault) begin
      next_r.mode = ST_DISABLED;
    end
    // Drive stays powered through ramp and hold; brake only while enabled
    next_r.drive_en = next_r.mode != ST_DISABLED;
    next_r.brake_on = next_r.mode == ST_ENABLED;
    // Polarity last, after sequencing, so the pin sees one clean edge
    pin_level  = brake_mode ? next_r.brake_on : user_out_i;
    next_r.pin = pin_level ^ polarity_invert_i;
  end

  // Single flop stage for every output, pin included
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{mode: ST_DISABLED, hold_left: `BSQ_HOLD_RESET, tick: `BSQ_TICK_RESET,
             drive_en: 1'b0, brake_on: 1'b0, pin: `BSQ_PIN_RESET};
    end else begin
      r <= next_r;
    end
  end

  assign drive_enabled_o = r.drive_en;
  assign brake_release_o = r.brake_on;
  assign out_pin_o       = r.pin;
  assign ramp_active_o   = (r.mode == ST_RAMP) || (r.mode == ST_HOLD);
  assign state_o         = r.mode;

  // Helper: cycles spent waiting to enable after a granted enable command
  logic [31:0] en_wait;
  logic        en_pending;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_pending <= 1'b0;
      en_wait    <= 32'h0000_0000;
    end else if (r.drive_en || fault || disable_cmd_i) begin
      en_pending <= 1'b0;
      en_wait    <= 32'h0000_0000;
    end else if (enable_cmd_i || en_pending) begin
      en_pending <= 1'b1;
      en_wait    <= en_wait + 32'h0000_0001;
    end
  end

  sequence s_quiet;
    !fault && !disable_cmd_i;
  endsequence

  sequence s_released;
    drive_enabled_o && brake_release_o;
  endsequence

  property p_pin_plain;
    @(posedge clk_i) disable iff (!rst_b_i)
      (brake_mode && !polarity_invert_i) |=> (out_pin_o == brake_release_o) && (brake_release_o || !out_pin_o);
  endproperty
  a_pin_plain: assert property (p_pin_plain) else $error("pin not off with brake held");

  property p_pin_on;
    @(posedge clk_i) disable iff (!rst_b_i)
      (brake_mode && !polarity_invert_i) ##1 brake_release_o |-> out_pin_o;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin not driven with brake released");

  property p_pin_inv;
    @(posedge clk_i) disable iff (!rst_b_i)
      (brake_mode && polarity_invert_i) |=> out_pin_o == !brake_release_o;
  endproperty
  a_pin_inv: assert property (p_pin_inv) else $error("inverted pin wrong");

  property p_disable_seq;
    @(posedge clk_i) disable iff (!rst_b_i)
      (r.mode == ST_ENABLED && disable_cmd_i && !fault) |=> !brake_release_o && drive_enabled_o;
  endproperty
  a_disable_seq: assert property (p_disable_seq) else $error("disable did not drop brake first");

  property p_enable_now;
    @(posedge clk_i) disable iff (!rst_b_i)
      ((r.mode == ST_DISABLED && enable_cmd_i) and s_quiet) |=> s_released;
  endproperty
  a_enable_now: assert property (p_enable_now) else $error("enable not simultaneous");

  property p_enable_bound;
    @(posedge clk_i) disable iff (!rst_b_i)
      en_wait <= 32'(ENABLE_MAX_CYC);
  endproperty
  a_enable_bound: assert property (p_enable_bound) else $error("enable took too long");

  property p_user_mode;
    @(posedge clk_i) disable iff (!rst_b_i)
      !brake_mode |=> out_pin_o == ($past(user_out_i) ^ $past(polarity_invert_i));
  endproperty
  a_user_mode: assert property (p_user_mode) else $error("non-brake mode pin wrong");

  property p_follow;
    @(posedge clk_i) disable iff (!rst_b_i)
      brake_release_o |-> drive_enabled_o && (r.mode == ST_ENABLED);
  endproperty
  a_follow: assert property (p_follow) else $error("brake released while not enabled");

  property p_hold_expire;
    @(posedge clk_i) disable iff (!rst_b_i)
      (r.mode == ST_HOLD && r.hold_left == 16'h0000) |=> !drive_enabled_o;
  endproperty
  a_hold_expire: assert property (p_hold_expire) else $error("hold expiry did not disable");

  property p_fault;
    @(posedge clk_i) disable iff (!rst_b_i)
      fault |=> !drive_enabled_o && !brake_release_o && state_o == ST_DISABLED;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not disable at once");

  property p_hold_start;
    @(posedge clk_i) disable iff (!rst_b_i)
      ((r.mode == ST_RAMP && stopped) and s_quiet) |=> (r.mode == ST_HOLD) && !brake_release_o;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold count did not start braked");

  property p_second_disable;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ramp_active_o && disable_cmd_i) |=> !drive_enabled_o;
  endproperty
  a_second_disable: assert property (p_second_disable) else $error("second disable not immediate");

endmodule

// File: include/brake_seq_defs.svh
// Constants for the holding-brake output sequencer.
// Assumes a 50 MHz control clock; included by bare name.
`ifndef BRAKE_SEQ_DEFS_SVH
`define BRAKE_SEQ_DEFS_SVH

`define BSQ_CLK_PERIOD_NS   20
`define BSQ_NS_PER_MS       1000000
`define BSQ_ENABLE_MAX_NS   1500000
`define BSQ_STOP_QUAL_MS    50
`define BSQ_OUT_MODE_BRAKE  3'h2
`define BSQ_PIN_RESET       1'b0
`define BSQ_HOLD_RESET      16'h0000
`define BSQ_TICK_RESET      16'h0000

`endif

// File: include/brake_seq_pkg.sv
// Types shared by the brake sequencer and its stop qualifier.
// No assumptions beyond a SystemVerilog compiler.
package brake_seq_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_DISABLED = 2'b00,
    ST_ENABLED  = 2'b01,
    ST_RAMP     = 2'b10,
    ST_HOLD     = 2'b11
  } seq_state_t;

  typedef struct packed {
    seq_state_t  mode;
    logic [15:0] hold_left;
    logic [15:0] tick;
    logic        drive_en;
    logic        brake_on;
    logic        pin;
  } seq_regs_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        stopped;
  } qual_regs_t;

endpackage

// File: rtl/stop_qualifier.sv
// Judges the motor stopped once speed has stayed under a threshold.
// Assumes speed and threshold are synchronous magnitudes.
`timescale 1ns/100ps
`include "brake_seq_defs.svh"
module stop_qualifier
  import brake_seq_pkg::*;
#(
  parameter int QUAL_CYC = `BSQ_STOP_QUAL_MS * (`BSQ_NS_PER_MS / `BSQ_CLK_PERIOD_NS),
  parameter int SPEED_W  = 16
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               arm_i,
  input  wire logic [SPEED_W-1:0] speed_i,
  input  wire logic [SPEED_W-1:0] threshold_i,
  output logic                    stopped_o
);

  qual_regs_t r;
  qual_regs_t next_r;
  logic       below;

  assign below = speed_i < threshold_i;

  // Any excursion to or above the threshold restarts the interval
  always_comb begin
    next_r = r;
    if (!arm_i || !below) begin
      next_r.cnt     = 32'h0000_0000;
      next_r.stopped = 1'b0;
    end else if (r.cnt >= 32'(QUAL_CYC - 1)) begin
      next_r.stopped = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign stopped_o = r.stopped;

  property p_qual_min;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(stopped_o) |-> $past(below, 1) && $past(below, 2) && $past(arm_i, 1);
  endproperty
  a_qual_min: assert property (p_qual_min) else $error("stopped without qualification");

endmodule

// File: tb/brake_relay.sv
// Relay and holding brake driven by the sequencer's output pin.
// Assumes one clock; armature pull-in shortened for simulation.
`timescale 1ns/100ps
module brake_relay #(
  parameter int PULL_CYC = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic coil_i,
  output logic [4:0] volts_o,
  output logic       shaft_free_o
);
  int cnt;
  // Coil sees 24 V only while the pin is high
  assign volts_o = coil_i ? 5'h18 : 5'h00;
  // Armature lags the coil, so the shaft frees late
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      cnt <= 0;
    else
      cnt <= coil_i ? ((cnt < PULL_CYC) ? cnt + 1 : cnt) : 0;
  end
  assign shaft_free_o = (cnt == PULL_CYC);
endmodule

// File: tb/test_brake_seq.sv
// Self-checking bench for the brake sequencer with a relay model.
// Assumes shortened tick and qualification counts.
`timescale 1ns/100ps
module test_brake_seq;
  import brake_seq_pkg::*;
  localparam int MS = 10;
  localparam int QC = 20;
  logic        clk_i, rst_b_i, inv, uo, hf, drv, brk, pin, ramp, free;
  logic [3:0]  cmd;
  logic [15:0] spd, thr, hold;
  logic [2:0]  mode;
  logic [1:0]  st;
  logic [4:0]  volts;
  int          n_fail, checks, m_st;

  brake_seq #(.MS_TICK_CYC(MS), .STOP_QUAL_CYC(QC)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .enable_cmd_i(cmd[0]), .disable_cmd_i(cmd[1]),
    .torque_cut_input_i(cmd[2] | hf), .feedback_lost_i(cmd[3]), .speed_i(spd),
    .halt_velocity_threshold_i(thr), .brake_hold_time_i(hold), .out_mode_i(mode),
    .polarity_invert_i(inv), .user_out_i(uo), .drive_enabled_o(drv), .brake_release_o(brk),
    .out_pin_o(pin), .ramp_active_o(ramp), .state_o(st));
  brake_relay relay (.clk_i(clk_i), .rst_b_i(rst_b_i), .coil_i(pin), .volts_o(volts), .shaft_free_o(free));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic summarize();
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_st(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare every output with the model state
  task automatic check_all();
    logic eb;
    eb = (m_st == 1);
    cmp_st(st, 2'(m_st));
    cmp_bit(drv, m_st != 0);
    cmp_bit(brk, eb);
    cmp_bit(pin, ((mode == 3'h2) ? eb : uo) ^ inv);
    cmp_bit(ramp, m_st >= 2);
  endtask

  // One-cycle command pulse: 0 enable, 1 disable, 2 torque cut, 3 feedback lost
  task automatic act(input int w);
    @(posedge clk_i);
    cmd <= 4'h1 << w;
    @(posedge clk_i);
    cmd <= 4'h0;
    if (w >= 2)
      m_st = 0;
    else if (w == 1)
      m_st = (m_st == 1) ? 2 : 0;
    else if (m_st == 0 && !hf)
      m_st = 1;
    #1;
    check_all();
  endtask

  // Sweep every output mode with random polarity and user level
  task automatic sweep();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      mode <= 3'(i);
      inv  <= 1'($urandom);
      uo   <= 1'($urandom);
      @(posedge clk_i);
      #1;
      check_all();
    end
    // Brake mode inverted at least once, whatever the random draws gave
    @(posedge clk_i);
    mode <= 3'h2;
    inv  <= 1'b1;
    @(posedge clk_i);
    #1;
    check_all();
    @(posedge clk_i);
    mode <= 3'h2;
    inv  <= 1'b0;
  endtask

  // Full ramp to stop; g adds a speed glitch that must restart qualification
  task automatic stop_run(input int n, input bit g);
    int c;
    hold <= 16'(n);
    act(0);
    act(1);
    @(posedge clk_i);
    spd <= thr - 16'h1;
    if (g) begin
      repeat (QC - 5) @(posedge clk_i);
      spd <= thr;
      @(posedge clk_i);
      spd <= thr - 16'h1;
    end
    c = 0;
    while (st !== 2'b11 && c < 200) begin
      @(posedge clk_i);
      #1;
      c++;
    end
    cmp_bit(c >= QC && c <= QC + 3, 1'b1);
    m_st = 3;
    check_all();
    c = 0;
    while (st === 2'b11 && c < 500) begin
      @(posedge clk_i);
      #1;
      c++;
    end
    cmp_bit(c >= MS * n && c <= MS * n + 3, 1'b1);
    m_st = 0;
    check_all();
    @(posedge clk_i);
    spd <= thr + 16'(1 + $urandom_range(500));
  endtask

  // Watchdog sized well above the expected run
  initial begin
    #(20 * 20000);
    n_fail++;
    summarize();
  end

  initial begin
    void'($urandom(32'h70d9ecce));
    rst_b_i = 1'b0;
    cmd = 4'h0;
    hf = 1'b0;
    inv = 1'b0;
    uo = 1'b0;
    mode = 3'h2;
    hold = 16'h0001;
    thr = 16'h0100 + 16'($urandom_range(1000));
    spd = thr + 16'h0010;
    m_st = 0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check_all();
    sweep();
    act(0);
    cmp_bit(volts === 5'h18, 1'b1);
    repeat (4) @(posedge clk_i);
    #1;
    cmp_bit(free, 1'b1);
    act(0);
    sweep();
    act(1);
    cmp_bit(volts === 5'h00, 1'b1);
    act(0);
    act(1);
    act(1);
    for (int w = 2; w < 4; w++) begin
      act(0);
      act(w);
      act(0);
      act(1);
      act(w);
    end
    @(posedge clk_i);
    hf <= 1'b1;
    act(0);
    @(posedge clk_i);
    hf <= 1'b0;
    stop_run(1, 1'b0);
    stop_run(3, 1'b1);
    stop_run($urandom_range(4, 1), 1'b0);
    summarize();
  end
endmodule
